//--- rtl/sctl_clock_ctrl.sv
`include "sctl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sctl_clock_ctrl #(
  parameter logic [7:0] PWRDN_STARTUP = `SCTL_PWRDN_CYCLES
) (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // avalon-mm slave, byte address
  input  wire logic [7:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // fuses and factory data, static pins
  input  wire logic                 div8_boot_fuse_i,
  input  wire logic [7:0]           factory_trim_i,
  input  wire logic                 xtal_selected_i,
  // core side
  input  wire logic                 sleep_instr_i,
  input  wire sctl_pkg::sctl_wake_s wake_i,
  output logic                      cpu_stall_o,
  output logic                      wake_resume_o,
  // oscillator trim
  output logic                      trim_range_bit_o,
  output logic [6:0]                trim_fine_field_o,
  // divided clock and domain enables
  output logic                      sysclk_tick_o,
  output sctl_pkg::sctl_gate_s      gate_o
);

  // register hit on a word-aligned byte address
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  // counter mask for a select code
  function automatic logic [7:0] div_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = 8'hFF;
    if (sel <= `SCTL_DIV_SEL_MAX)
    begin
      m = 8'((9'h001 << sel) - 9'h001);
    end
    div_mask = m;
  endfunction

  // static pins pass two flops before use
  logic       fuse_meta;
  logic       fuse_sync;
  logic [7:0] ftrim_meta;
  logic [7:0] ftrim_sync;
  logic       xtal_meta;
  logic       xtal_sync;

  always_ff @(posedge clk_sys_i)
  begin
    fuse_meta  <= div8_boot_fuse_i;
    fuse_sync  <= fuse_meta;
    ftrim_meta <= factory_trim_i;
    ftrim_sync <= ftrim_meta;
    xtal_meta  <= xtal_selected_i;
    xtal_sync  <= xtal_meta;
  end

  // register state
  logic [7:0] trim;
  logic [3:0] div_sel;
  logic       unlock;
  logic [2:0] unlock_cnt;
  logic       sleep_arm;
  logic [1:0] sleep_kind;

  // bus decode
  wire       wr_lane0  = avs_write_i & avs_byteenable_i[0];
  wire [7:0] wdata     = avs_writedata_i[7:0];
  wire       hit_div   = reg_hit(avs_address_i, `SCTL_IDX_DIV_CTRL);
  wire       hit_trim  = reg_hit(avs_address_i, `SCTL_IDX_TRIM);
  wire       hit_mcu   = reg_hit(avs_address_i, `SCTL_IDX_MCU_CTRL);
  wire       hit_stat  = reg_hit(avs_address_i, `SCTL_IDX_STATUS);
  wire       wr_div    = wr_lane0 & hit_div;
  wire       wr_trim   = wr_lane0 & hit_trim;
  wire       wr_mcu    = wr_lane0 & hit_mcu;

  // unlock decode
  // exact unlock word
  wire unlock_req   = wr_div & (wdata == `SCTL_DIV_UNLOCK_WORD);
  wire sel_write    = wr_div & ~wdata[`SCTL_DIV_UNLOCK_BIT];
  wire sel_accept   = sel_write & unlock;
  wire unlock_tmo   = unlock & (unlock_cnt == `SCTL_UNLOCK_CYCLES - 3'h1);

  // factory trim at reset; software may overwrite
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      trim <= ftrim_sync;
    else if (wr_trim)
      trim <= wdata;
  end

  // range bit and fine field drive the oscillator
  assign trim_range_bit_o  = trim[`SCTL_TRIM_RANGE_BIT];
  assign trim_fine_field_o = trim[`SCTL_TRIM_FINE_MSB:0];

  // unlock window; a second unlock write is ignored
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      unlock     <= 1'b0;
      unlock_cnt <= 3'h0;
    end
    // select write or timeout closes window
    else if (unlock)
    begin
      unlock     <= ~(unlock_tmo | sel_write);
      unlock_cnt <= 3'(unlock_cnt + 3'h1);
    end
    else if (unlock_req)
    begin
      unlock     <= 1'b1;
      unlock_cnt <= 3'h0;
    end
  end

  // select field; fuse chooses the boot value
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      div_sel <= fuse_sync ? `SCTL_DIV_SEL_FUSE : `SCTL_DIV_SEL_RST;
    else if (sel_accept)
      div_sel <= wdata[`SCTL_DIV_SEL_MSB:0];
  end

  // sleep control bits
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sleep_arm  <= 1'b0;
      sleep_kind <= 2'h0;
    end
    else if (wr_mcu)
    begin
      sleep_arm  <= wdata[`SCTL_SLEEP_ARM_BIT];
      sleep_kind <= wdata[`SCTL_SLEEP_KIND_MSB:`SCTL_SLEEP_KIND_LSB];
    end
  end

  // divider: new setting only applied at a tick of the old one,
  // so the first new period is a full one
  logic [7:0] div_cnt;
  logic [3:0] act_sel;
  wire  [7:0] act_mask = div_mask(act_sel);
  wire        div_wrap = (div_cnt == act_mask);

  // power-of-two divide, reserved codes clamp to 256
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_cnt       <= 8'h00;
      act_sel       <= `SCTL_DIV_SEL_RST;
      sysclk_tick_o <= 1'b0;
    end
    else
    begin
      sysclk_tick_o <= div_wrap;
      if (div_wrap)
      begin
        div_cnt <= 8'h00;
        // switch only at a period boundary
        act_sel <= div_sel;
      end
      else
      begin
        div_cnt <= 8'(div_cnt + 8'h01);
      end
    end
  end

  // sleep state machine
  sctl_pkg::sctl_state_e state;
  sctl_pkg::sctl_state_e next_state;
  sctl_pkg::sctl_kind_e  kind;
  logic [7:0]            wait_cnt;
  logic [7:0]            next_wait_cnt;

  // kind 11 without a crystal behaves as power-down
  wire kind_standby = (sleep_kind == 2'h3) & xtal_sync;
  wire [1:0] eff_kind = (sleep_kind == 2'h3 && !xtal_sync)
                        ? 2'h2 : sleep_kind;

  // wake sources; ext_irq_zero only counts as level outside idle
  // edge requests ignored outside idle
  wire ext0_lvl  = wake_i.ext_irq_zero & wake_i.ext_irq_zero_level;
  wire wake_any  = wake_i.ext_irq_zero | wake_i.pin_change
                 | wake_i.nvm_ready | wake_i.adc_done
                 | wake_i.other_io | wake_i.watchdog;
  wire wake_noise = ext0_lvl | wake_i.pin_change | wake_i.nvm_ready
                  | wake_i.adc_done | wake_i.watchdog;
  wire wake_deep  = ext0_lvl | wake_i.pin_change | wake_i.watchdog;

  logic wake_hit;
  logic [7:0] startup_len;

  // wake source and start-up length by mode
  always_comb
  begin
    wake_hit    = 1'b0;
    startup_len = 8'h00;
    unique case (kind)
      sctl_pkg::SCTL_KIND_IDLE:
        wake_hit = wake_any;
      sctl_pkg::SCTL_KIND_NOISE:
        wake_hit = wake_noise;
      sctl_pkg::SCTL_KIND_PWRDN:
      begin
        wake_hit    = wake_deep;
        startup_len = PWRDN_STARTUP;
      end
      sctl_pkg::SCTL_KIND_STANDBY:
      begin
        wake_hit    = wake_deep;
        startup_len = `SCTL_STANDBY_CYCLES;
      end
    endcase
  end

  // next state
  always_comb
  begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    unique case (state)
      sctl_pkg::SCTL_RUN:
      begin
        if (sleep_instr_i && sleep_arm)
          next_state = sctl_pkg::SCTL_SLEEP;
      end
      sctl_pkg::SCTL_SLEEP:
      begin
        if (wake_hit)
        begin
          next_wait_cnt = 8'h00;
          next_state    = (startup_len == 8'h00)
                          ? sctl_pkg::SCTL_STALL
                          : sctl_pkg::SCTL_STARTUP;
        end
      end
      sctl_pkg::SCTL_STARTUP:
      begin
        next_wait_cnt = 8'(wait_cnt + 8'h01);
        if (wait_cnt == 8'(startup_len - 8'h01))
        begin
          next_wait_cnt = 8'h00;
          next_state    = sctl_pkg::SCTL_STALL;
        end
      end
      sctl_pkg::SCTL_STALL:
      begin
        next_wait_cnt = 8'(wait_cnt + 8'h01);
        if (wait_cnt == `SCTL_STALL_CYCLES - 8'h01)
        begin
          next_wait_cnt = 8'h00;
          next_state    = sctl_pkg::SCTL_RUN;
        end
      end
    endcase
  end

  // state registers; kind latched when sleep begins
  // reset forces run from any sleep state
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state    <= sctl_pkg::SCTL_RUN;
      kind     <= sctl_pkg::SCTL_KIND_IDLE;
      wait_cnt <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      if (state == sctl_pkg::SCTL_RUN)
        kind <= sctl_pkg::sctl_kind_e'(kind_standby ? 2'h3 : eff_kind);
    end
  end

  // domain enables; gating only, so core state is kept
  sctl_pkg::sctl_gate_s next_gate;

  // clocks stop, storage is never reset here
  always_comb
  begin
    next_gate = 5'b11111;
    unique case (next_state)
      sctl_pkg::SCTL_RUN:
        next_gate = 5'b11111;
      sctl_pkg::SCTL_SLEEP:
      begin
        unique case (eff_kind_sel(state, kind, kind_standby, eff_kind))
          2'h0: next_gate = 5'b00111;
          2'h1: next_gate = 5'b00011;
          2'h2: next_gate = 5'b00000;
          2'h3: next_gate = 5'b00001;
        endcase
      end
      // oscillator restarting, domains still held
      sctl_pkg::SCTL_STARTUP:
        next_gate = 5'b00001;
      // core halted, rest running
      sctl_pkg::SCTL_STALL:
        next_gate = 5'b01111;
    endcase
  end

  // kind in force: fresh from registers on entry, latched after
  function automatic logic [1:0] eff_kind_sel(
    input sctl_pkg::sctl_state_e st,
    input sctl_pkg::sctl_kind_e  latched,
    input logic                  stby,
    input logic [1:0]            fresh);
    eff_kind_sel = (st == sctl_pkg::SCTL_RUN)
                   ? (stby ? 2'h3 : fresh) : 2'(latched);
  endfunction

  // registered outputs of the sleep logic
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      gate_o        <= 5'b11111;
      cpu_stall_o   <= 1'b0;
      wake_resume_o <= 1'b0;
    end
    else
    begin
      gate_o        <= next_gate;
      cpu_stall_o   <= (next_state != sctl_pkg::SCTL_RUN);
      // one pulse as the core restarts after the instruction
      wake_resume_o <= (state == sctl_pkg::SCTL_STALL)
                     & (next_state == sctl_pkg::SCTL_RUN);
    end
  end

  // read mux; status shows live block state
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_div)
    begin
      rd_byte = {unlock, 3'h0, div_sel};
    end
    else if (hit_trim)
      rd_byte = trim;
    else if (hit_mcu)
      rd_byte = {2'h0, sleep_arm, sleep_kind, 3'h0};
    else if (hit_stat)
    begin
      rd_byte = 8'h00;
      rd_byte[3:0] = act_sel;
      rd_byte[`SCTL_STAT_SLEEP_BIT] = (state == sctl_pkg::SCTL_SLEEP);
      rd_byte[`SCTL_STAT_STALL_BIT] = (state != sctl_pkg::SCTL_RUN);
      rd_byte[`SCTL_STAT_UNLK_BIT]  = unlock;
    end
  end

  // reads take two cycles so read data come from a flop;
  // writes finish in the cycle they are seen
  logic rd_ack;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_ack         <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      rd_ack <= avs_read_i & ~rd_ack;
      if (avs_read_i && !rd_ack)
        avs_readdata_o <= {24'h000000, rd_byte};
    end
  end

  assign avs_waitrequest_o = avs_read_i & ~rd_ack;

endmodule

`default_nettype wire

//--- rtl/sctl_defines.svh
`ifndef SCTL_DEFINES_SVH
`define SCTL_DEFINES_SVH

// register indexes; byte address is four times the index
`define SCTL_IDX_DIV_CTRL    6'h26
`define SCTL_IDX_TRIM        6'h27
`define SCTL_IDX_MCU_CTRL    6'h28
`define SCTL_IDX_STATUS      6'h29

// clock_divider_control fields
`define SCTL_DIV_UNLOCK_BIT  7
`define SCTL_DIV_SEL_MSB     3
`define SCTL_DIV_UNLOCK_WORD 8'h80
`define SCTL_DIV_SEL_RST     4'h0
`define SCTL_DIV_SEL_FUSE    4'h3
`define SCTL_DIV_SEL_MAX     4'h8

// rc_oscillator_trim fields
`define SCTL_TRIM_RANGE_BIT  7
`define SCTL_TRIM_FINE_MSB   6

// mcu_control_reg fields
`define SCTL_SLEEP_ARM_BIT   5
`define SCTL_SLEEP_KIND_MSB  4
`define SCTL_SLEEP_KIND_LSB  3

// status fields
`define SCTL_STAT_SLEEP_BIT  4
`define SCTL_STAT_STALL_BIT  5
`define SCTL_STAT_UNLK_BIT   6

// timing counts in clk_sys_i cycles
`define SCTL_UNLOCK_CYCLES   3'h4
`define SCTL_STALL_CYCLES    8'h04
`define SCTL_STANDBY_CYCLES  8'h06
`define SCTL_PWRDN_CYCLES    8'h10

`endif

//--- rtl/sctl_pkg.sv
package sctl_pkg;

  // sleep controller states
  typedef enum logic [1:0] {
    SCTL_RUN,
    SCTL_SLEEP,
    SCTL_STARTUP,
    SCTL_STALL
  } sctl_state_e;

  // sleep_kind_field encodings
  typedef enum logic [1:0] {
    SCTL_KIND_IDLE,
    SCTL_KIND_NOISE,
    SCTL_KIND_PWRDN,
    SCTL_KIND_STANDBY
  } sctl_kind_e;

  // enabled interrupt requests that may wake the core
  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_zero_level;
    logic pin_change;
    logic nvm_ready;
    logic adc_done;
    logic other_io;
    logic watchdog;
  } sctl_wake_s;

  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic osc;
  } sctl_gate_s;

endpackage

//--- sim/sctl_clock_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module sctl_clock_ctrl_props (
  // clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 rst_i,
  // bus and static pins
  input wire logic [7:0]           avs_address_i,
  input wire logic                 avs_read_i,
  input wire logic [31:0]          avs_readdata_o,
  input wire logic                 avs_waitrequest_o,
  input wire logic [7:0]           factory_trim_i,
  // core side and clock outputs
  input wire logic                 sleep_instr_i,
  input wire logic                 cpu_stall_o,
  input wire logic                 wake_resume_o,
  input wire logic                 trim_range_bit_o,
  input wire logic [6:0]           trim_fine_field_o,
  input wire logic                 sysclk_tick_o,
  input wire sctl_pkg::sctl_gate_s gate_o
);
  logic [4:0] gv;
  logic [8:0] gap;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // flat view of the gate struct
  assign gv = gate_o;

  // cycles since the last tick; saturating is not needed, it fails first
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || sysclk_tick_o)
      gap <= 9'h000;
    else
      gap <= gap + 9'h001;
  end

  property p_trim_rst;
    $fell(rst_i) |-> {trim_range_bit_o, trim_fine_field_o} == factory_trim_i;
  endproperty
  a_trim_rst: assert property (p_trim_rst)
    else $error("trim not factory after reset");

  property p_rsv_zero;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h98
      |-> avs_readdata_o[31:8] == 24'h0 && avs_readdata_o[6:4] == 3'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved divider bits not zero");

  property p_tick_gap;
    gap < 9'h100;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick gap above 256");

  property p_sleep_entry;
    $rose(cpu_stall_o) |-> $past(sleep_instr_i)
      && gv inside {5'h07, 5'h03, 5'h00, 5'h01};
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered without instruction");

  property p_stall_four;
    wake_resume_o |-> gv == 5'h1F && $past(gv) == 5'h0F
      && $past(gv, 4) == 5'h0F && $past(gv, 5) != 5'h0F;
  endproperty
  a_stall_four: assert property (p_stall_four)
    else $error("wake stall not four cycles");

  property p_resume_pulse;
    wake_resume_o |=> !wake_resume_o && !cpu_stall_o;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse)
    else $error("resume pulse too long");

  property p_run_gates;
    !cpu_stall_o |-> gv == 5'h1F;
  endproperty
  a_run_gates: assert property (p_run_gates)
    else $error("clock gated while running");

  property p_stall_gates;
    cpu_stall_o |-> gv inside {5'h07, 5'h03, 5'h00, 5'h01, 5'h0F};
  endproperty
  a_stall_gates: assert property (p_stall_gates)
    else $error("illegal gate pattern in sleep");

  property p_reset_wake;
    $fell(rst_i) |-> !cpu_stall_o && !wake_resume_o;
  endproperty
  a_reset_wake: assert property (p_reset_wake)
    else $error("reset did not wake core");
endmodule

bind sctl_clock_ctrl sctl_clock_ctrl_props u_props (
  .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_readdata_o,
  .avs_waitrequest_o, .factory_trim_i, .sleep_instr_i, .cpu_stall_o,
  .wake_resume_o, .trim_range_bit_o, .trim_fine_field_o, .sysclk_tick_o,
  .gate_o
);

`default_nettype wire

//--- sim/tb_sysclk_prescale_trim_sleep.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sysclk_prescale_trim_sleep;
  logic                 clk_sys_i, rst_i, avs_read_i, avs_write_i;
  logic [7:0]           avs_address_i, factory_trim_i;
  logic [31:0]          avs_writedata_i, avs_readdata_o;
  logic [3:0]           avs_byteenable_i;
  logic                 avs_waitrequest_o, div8_boot_fuse_i;
  logic                 xtal_selected_i, sleep_instr_i, cpu_stall_o;
  logic                 wake_resume_o, trim_range_bit_o, sysclk_tick_o;
  logic [6:0]           trim_fine_field_o;
  sctl_pkg::sctl_wake_s wake_i;
  sctl_pkg::sctl_gate_s gate_o;
  int                   n_mismatch, num_checks;

  // short power-down start-up keeps the run brief
  sctl_clock_ctrl #(.PWRDN_STARTUP(8'h02)) uut (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .div8_boot_fuse_i, .factory_trim_i,
    .xtal_selected_i, .sleep_instr_i, .wake_i, .cpu_stall_o,
    .wake_resume_o, .trim_range_bit_o, .trim_fine_field_o,
    .sysclk_tick_o, .gate_o
  );

  // 100 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string s, input logic [31:0] g,
                     input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // write held until waitrequest is seen low; caller releases
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
  endtask

  task automatic rel;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input string s);
    avs_address_i <= a;
    avs_write_i   <= 1'b0;
    avs_read_i    <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    chk(s, avs_readdata_o, {24'h0, e});
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rst(input logic f);
    div8_boot_fuse_i <= f;
    rst_i            <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // third gap is a full period of the adopted code
  task automatic per(input logic [8:0] e);
    logic [8:0] c;
    repeat (3)
    begin
      c = 9'h000;
      do
      begin
        @(posedge clk_sys_i);
        c++;
      end while (sysclk_tick_o !== 1'b1 && c < 9'h1FF);
    end
    chk("tick period", c, e);
  endtask

  task automatic slp;
    sleep_instr_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_instr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic t_reset;
    rdc(8'h98, 8'h03, "select reset");
    rdc(8'h9C, 8'hA5, "trim reset");
    per(9'h008);
    $display("test reset done");
  endtask

  task automatic t_trim;
    wr(8'h9C, 8'h85);
    wr(8'h9C, 8'h7F);
    rel;
    chk("range low", trim_range_bit_o, 1'b0);
    chk("fine top", trim_fine_field_o, 7'h7F);
    wr(8'h9C, 8'h80);
    rel;
    chk("range high", trim_range_bit_o, 1'b1);
    chk("fine bottom", trim_fine_field_o, 7'h00);
    avs_byteenable_i <= 4'h0;
    wr(8'h9C, 8'h9F);
    avs_byteenable_i <= 4'h1;
    rel;
    rdc(8'h9C, 8'h80, "lane off");
    wr(8'h40, 8'h55);
    rel;
    rdc(8'h40, 8'h00, "unmapped");
    $display("test trim done");
  endtask

  task automatic t_div;
    for (int n = 0; n <= 8; n++)
    begin
      wr(8'h98, 8'h80);
      wr(8'h98, 8'(n));
      rel;
      rdc(8'h98, 8'(n), "select code");
      per(9'(1 << n));
    end
    wr(8'h98, 8'h80);
    rdc(8'h98, 8'h88, "unlock seen");
    // a write at the fifth edge falls after the window has closed
    rel;
    wr(8'h98, 8'h02);
    rel;
    rdc(8'h98, 8'h08, "after timeout");
    wr(8'h98, 8'h81);
    wr(8'h98, 8'h02);
    rel;
    rdc(8'h98, 8'h08, "bad unlock");
    repeat (4) wr(8'h98, 8'h80);
    rel;
    wr(8'h98, 8'h02);
    rel;
    rdc(8'h98, 8'h08, "no restart");
    wr(8'h98, 8'h80);
    wr(8'h98, 8'h7F);
    rel;
    rdc(8'h98, 8'h0F, "reserved bits");
    per(9'h100);
    rdc(8'hA4, 8'h0F, "status code");
    $display("test divider done");
  endtask

  task automatic t_sleep;
    int         base, c;
    logic [4:0] ge [5] = '{5'h07, 5'h03, 5'h00, 5'h01, 5'h00};
    int         de [5] = '{0, 0, 2, 6, 2};
    base = 0;
    wr(8'hA0, 8'h00);
    rel;
    slp;
    chk("no arm", cpu_stall_o, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      // last pass: kind 11 without a crystal acts as power-down
      if (k == 4)
        xtal_selected_i <= 1'b0;
      wr(8'hA0, 8'h20 | 8'((k == 4 ? 3 : k) << 3));
      rel;
      slp;
      chk("sleep gates", gate_o, ge[k]);
      if (k == 2)
      begin
        wake_i.ext_irq_zero <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("edge wake", cpu_stall_o, 1'b1);
      end
      wake_i <= (k == 3) ? 7'h60 : 7'h01;
      c = 0;
      do
      begin
        @(posedge clk_sys_i);
        c++;
      end while (wake_resume_o !== 1'b1 && c < 100);
      wake_i <= '0;
      if (k == 0)
        base = c;
      chk("wake delay", 32'(c - base), 32'(de[k]));
      @(posedge clk_sys_i);
      chk("running", cpu_stall_o, 1'b0);
    end
    $display("test sleep done");
  endtask

  task automatic t_rst;
    wr(8'hA0, 8'h30);
    rel;
    slp;
    chk("asleep", cpu_stall_o, 1'b1);
    rst(1'b0);
    chk("reset wake", cpu_stall_o, 1'b0);
    chk("reset gates", gate_o, 5'h1F);
    rdc(8'h98, 8'h00, "select no fuse");
    rdc(8'h9C, 8'hA5, "trim reload");
    $display("test sleep reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    n_mismatch       = 0;
    num_checks       = 0;
    rst_i            = 1'b1;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_address_i    = 8'h00;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'h1;
    div8_boot_fuse_i = 1'b1;
    factory_trim_i   = 8'hA5;
    xtal_selected_i  = 1'b1;
    sleep_instr_i    = 1'b0;
    wake_i           = '0;
    rst(1'b1);
    t_reset;
    t_trim;
    t_div;
    t_sleep;
    t_rst;
    stop_test;
  end

  // hang guard well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    n_mismatch++;
    stop_test;
  end
endmodule

`default_nettype wire
